// ===== cksp_pkg.sv
// Package: constants and carriers for the capacitive key scan port
package cksp_pkg;
    localparam int NIBBLE_W = 4;
    localparam int SENSE_W = 8;
    localparam int SCAN_FULL = 16;
    localparam int SCAN_REDUCED = 11;
    // Address phase field positions on the nibble port
    localparam int ADDR_LSB = 0;
    localparam int INSTR_LSB = 2;
    localparam logic [1:0] PORT_LOWER = 2'h0;
    localparam logic [1:0] PORT_UPPER = 2'h1;
    localparam logic [1:0] INSTR_READ = 2'h0;
    localparam logic [1:0] INSTR_WRITE = 2'h1;
    // Strobe rate limits, in Hz, and longest ALE period in clock cycles at 40 MHz
    localparam int CLK_HZ = 40000000;
    localparam int ALE_MIN_HZ = 66600;
    localparam int ALE_MAX_HZ = 733300;
    localparam int ALE_MAX_CYC = CLK_HZ / ALE_MIN_HZ;
    localparam logic [SENSE_W-1:0] SENSE_RST = 8'h00;
    localparam logic [NIBBLE_W-1:0] NIBBLE_RST = 4'h0;

    typedef struct packed {
        logic [1:0] instr;
        logic [1:0] port;
    } cksp_cmd_t;

    typedef struct packed {
        logic [NIBBLE_W-1:0] dout;
        logic [NIBBLE_W-1:0] oe;
    } cksp_port_drv_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ZERO = 2'b01,
        ST_ARMED = 2'b10,
        ST_SCAN = 2'b11
    } cksp_scan_st_t;
endpackage

// ===== cksp_top.sv
// Capacitive key scan port: host nibble port, scan decoder and sense readout
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`timescale 1ns/10ps
module cksp_top
    import cksp_pkg::*;
#(
    parameter int SCAN_LINES = cksp_pkg::SCAN_FULL
) (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_ale,
    input wire logic i_port_strobe_n,
    input wire logic [cksp_pkg::NIBBLE_W-1:0] i_host_nibble_port,
    output logic [cksp_pkg::NIBBLE_W-1:0] o_host_nibble_port,
    output logic [cksp_pkg::NIBBLE_W-1:0] o_host_nibble_port_oe,
    input wire logic [cksp_pkg::SENSE_W-1:0] i_sense_inputs,
    output logic [SCAN_LINES-1:0] o_scan_lines,
    output logic o_antiscan,
    output logic o_zeroing
);
    import cksp_pkg::*;

    // ------------------------------------------------------------------------
    // Strobe edge detection
    // ------------------------------------------------------------------------
    // Inputs are synchronous to i_sys_clk, so one stage suffices for edges
    logic ale_q;
    logic strb_n_q;
    logic ale_rise;
    logic ale_fall;
    logic strb_fall;
    logic strb_rise;

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            ale_q <= 1'b0;
            strb_n_q <= 1'b1;
        end else begin
            ale_q <= i_ale;
            strb_n_q <= i_port_strobe_n;
        end
    end

    assign ale_rise = i_ale && !ale_q;
    assign ale_fall = !i_ale && ale_q;
    assign strb_fall = !i_port_strobe_n && strb_n_q;
    assign strb_rise = i_port_strobe_n && !strb_n_q;

    function automatic logic cmd_ours(input cksp_cmd_t c);
        return (c.port == PORT_LOWER) || (c.port == PORT_UPPER);
    endfunction

    function automatic logic [SCAN_LINES-1:0] scan_decode(
        input logic [NIBBLE_W-1:0] code
    );
        logic [SCAN_LINES-1:0] v;
        v = '0;
        for (int k = 0; k < SCAN_LINES; k++) begin
            if (code == NIBBLE_W'(k)) begin
                v[k] = 1'b1;
            end
        end
        return v;
    endfunction

    // ------------------------------------------------------------------------
    // Address phase
    // ------------------------------------------------------------------------
    cksp_cmd_t cmd_q;
    logic cmd_valid_q;
    cksp_cmd_t cmd_in;

    assign cmd_in = cksp_cmd_t'(i_host_nibble_port);

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            cmd_q <= cksp_cmd_t'(NIBBLE_RST);
            cmd_valid_q <= 1'b0;
        end else if (strb_fall) begin
            cmd_q <= cmd_in;
            cmd_valid_q <= cmd_ours(cmd_in);
        end
    end

    logic is_write;
    logic is_read;
    assign is_write = cmd_valid_q && (cmd_q.instr == INSTR_WRITE);
    assign is_read = cmd_valid_q && (cmd_q.instr == INSTR_READ);

    // ------------------------------------------------------------------------
    // Write data and scan sequencing
    // ------------------------------------------------------------------------
    logic [NIBBLE_W-1:0] scan_code_q;
    cksp_scan_st_t st_q;
    logic wr_fall;

    // Write is decided at the same edge the command is captured
    assign wr_fall = strb_fall && cmd_ours(cmd_in)
        && (cmd_in.instr == INSTR_WRITE);

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            scan_code_q <= NIBBLE_RST;
        end else if (strb_rise && is_write) begin
            scan_code_q <= i_host_nibble_port;
        end
    end

    // Zeroing runs from the strobe fall to the next ALE rise; the host is
    // relied on to lift the strobe first, so that rise also starts the scan
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            st_q <= ST_IDLE;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (wr_fall) begin
                        st_q <= ST_ZERO;
                    end
                end
                ST_ZERO: begin
                    if (ale_rise) begin
                        st_q <= ST_SCAN;
                    end
                end
                ST_SCAN: begin
                    if (ale_fall) begin
                        st_q <= ST_IDLE;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    logic scan_start;
    logic scan_end;
    assign scan_start = (st_q == ST_ZERO) && ale_rise;
    assign scan_end = (st_q == ST_SCAN) && ale_fall;

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            o_zeroing <= 1'b0;
        end else if (wr_fall && st_q == ST_IDLE) begin
            o_zeroing <= 1'b1;
        end else if (scan_start) begin
            o_zeroing <= 1'b0;
        end
    end

    // Code arrives at strobe rise, before the ALE rise that starts the scan
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            o_scan_lines <= '0;
            o_antiscan <= 1'b1;
        end else if (scan_start) begin
            o_scan_lines <= scan_decode(scan_code_q);
            o_antiscan <= ~|scan_decode(scan_code_q);
        end else if (scan_end) begin
            o_scan_lines <= '0;
            o_antiscan <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Sense latch and read path
    // ------------------------------------------------------------------------
    logic [SENSE_W-1:0] sense_q;

    // Latched just before scanning closes, as the amplifier would
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            sense_q <= SENSE_RST;
        end else if (scan_end) begin
            sense_q <= i_sense_inputs;
        end
    end

    cksp_port_drv_t drv_q;

    // Drive from strobe fall until strobe rise; the host samples at the rise
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            drv_q <= '0;
        end else if (strb_fall && cmd_ours(cmd_in)
                && cmd_in.instr == INSTR_READ) begin
            drv_q.oe <= '1;
            if (cmd_in.port == PORT_UPPER) begin
                drv_q.dout <= sense_q[SENSE_W-1:NIBBLE_W];
            end else begin
                drv_q.dout <= sense_q[NIBBLE_W-1:0];
            end
        end else if (strb_rise) begin
            drv_q.oe <= '0;
        end
    end

    assign o_host_nibble_port = drv_q.dout;
    assign o_host_nibble_port_oe = drv_q.oe;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    sequence s_scan_on;
        ale_rise && st_q == ST_ZERO;
    endsequence

    sequence s_scan_active;
        |o_scan_lines && !o_antiscan;
    endsequence

    sequence s_scan_on_in;
        ale_rise && st_q == ST_ZERO && int'(scan_code_q) < SCAN_LINES;
    endsequence

    sequence s_scan_on_out;
        ale_rise && st_q == ST_ZERO && int'(scan_code_q) >= SCAN_LINES;
    endsequence

    property p_one_hot;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        $onehot0(o_scan_lines);
    endproperty
    a_one_hot: assert property (p_one_hot)
        else $error("more than one scan line active");

    property p_antiscan;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        o_antiscan == ~|o_scan_lines;
    endproperty
    a_antiscan: assert property (p_antiscan)
        else $error("antiscan not complement of scan");

    property p_scan_on;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        s_scan_on_in |=> s_scan_active;
    endproperty
    a_scan_on: assert property (p_scan_on)
        else $error("scan line not raised after ALE rise");

    property p_scan_absent;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        s_scan_on_out |=> o_scan_lines == '0 && o_antiscan;
    endproperty
    a_scan_absent: assert property (p_scan_absent)
        else $error("scan line raised for missing line");

    property p_scan_off;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (st_q == ST_SCAN && ale_fall) |=> o_scan_lines == '0;
    endproperty
    a_scan_off: assert property (p_scan_off)
        else $error("scan line not dropped on ALE fall");

    property p_scan_index;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        s_scan_on |=> o_scan_lines == (SCAN_LINES'(1) << $past(scan_code_q));
    endproperty
    a_scan_index: assert property (p_scan_index)
        else $error("wrong scan line selected");

    property p_zero_start;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (wr_fall && st_q == ST_IDLE) |=> o_zeroing;
    endproperty
    a_zero_start: assert property (p_zero_start)
        else $error("zeroing did not start");

    property p_zero_end;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        s_scan_on |=> !o_zeroing;
    endproperty
    a_zero_end: assert property (p_zero_end)
        else $error("zeroing did not end at ALE rise");

    property p_wr_data;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (strb_rise && is_write) |=> scan_code_q == $past(i_host_nibble_port);
    endproperty
    a_wr_data: assert property (p_wr_data)
        else $error("scan data not captured");

    property p_rd_upper;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (strb_fall && cmd_in == cksp_cmd_t'(4'h1))
            |=> o_host_nibble_port == sense_q[7:4] && &o_host_nibble_port_oe;
    endproperty
    a_rd_upper: assert property (p_rd_upper)
        else $error("upper nibble read wrong");

    property p_rd_lower;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (strb_fall && cmd_in == cksp_cmd_t'(4'h0))
            |=> o_host_nibble_port == sense_q[3:0] && &o_host_nibble_port_oe;
    endproperty
    a_rd_lower: assert property (p_rd_lower)
        else $error("lower nibble read wrong");

    property p_ignore;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (strb_fall && cmd_in.port[1]) |=> !cmd_valid_q
            && o_host_nibble_port_oe == '0;
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("responded to foreign port");

    property p_oe_read;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        |o_host_nibble_port_oe |-> is_read;
    endproperty
    a_oe_read: assert property (p_oe_read)
        else $error("port driven without a latched read");
endmodule

// ===== cksp_host_model.sv
// Host model: expanded I/O port strobes of an 8-bit controller
`timescale 1ns/10ps
module cksp_host_model #(
    parameter int ALE_HI = 8
) (
    input wire logic i_sys_clk,
    input wire logic [cksp_pkg::NIBBLE_W-1:0] i_host_nibble_port,
    output logic o_ale,
    output logic o_port_strobe_n,
    output logic [cksp_pkg::NIBBLE_W-1:0] o_host_nibble_port
);
    import cksp_pkg::*;
    int lo_cyc = 48;
    // ALE runs free, as the controller's does between accesses
    initial begin
        o_ale = 1'b0;
        o_port_strobe_n = 1'b1;
        o_host_nibble_port = 4'h0;
        forever begin
            repeat (lo_cyc) @(negedge i_sys_clk);
            o_ale = 1'b1;
            repeat (ALE_HI) @(negedge i_sys_clk);
            o_ale = 1'b0;
        end
    end
    task automatic start_access(input logic [1:0] instr,
                                input logic [1:0] port);
        @(negedge o_ale);
        @(negedge i_sys_clk);
        o_port_strobe_n = 1'b0;
        o_host_nibble_port = {instr, port};
    endtask
    task automatic do_write(input logic [1:0] port, input logic [3:0] code,
                            input logic [1:0] instr);
        start_access(instr, port);
        repeat (3) @(negedge i_sys_clk);
        o_host_nibble_port = code;
        repeat (3) @(negedge i_sys_clk);
        o_port_strobe_n = 1'b1;
        repeat (2) @(negedge i_sys_clk);
        // Released port has no pull: show the inverse, not the old value
        o_host_nibble_port = ~code;
    endtask
    task automatic do_read(input logic [1:0] port, output logic [3:0] data);
        start_access(INSTR_READ, port);
        @(negedge i_sys_clk);
        o_host_nibble_port = ~o_host_nibble_port;
        repeat (3) @(negedge i_sys_clk);
        data = i_host_nibble_port;
        o_port_strobe_n = 1'b1;
    endtask
endmodule

// ===== cksp_tb.sv
// Self-checking testbench for the capacitive key scan port
`timescale 1ns/10ps
module testbench;
    import cksp_pkg::*;
    logic clk, rstn, ale, strobe_n, antiscan, zeroing, antiscan_red;
    logic [NIBBLE_W-1:0] host_nib, dev_nib, dev_oe, nib_wire, rd;
    logic [SENSE_W-1:0] sense;
    logic [SCAN_FULL-1:0] scan;
    logic [SCAN_REDUCED-1:0] scan_red;
    int fail_count = 0;
    int samples_checked = 0;

    assign nib_wire = (dev_oe & dev_nib) | (~dev_oe & host_nib);

    cksp_host_model i_cksp_host_model (.i_sys_clk(clk),
        .i_host_nibble_port(nib_wire), .o_ale(ale),
        .o_port_strobe_n(strobe_n), .o_host_nibble_port(host_nib));
    cksp_top i_cksp_top (.i_sys_clk(clk), .i_resetn(rstn), .i_ale(ale),
        .i_port_strobe_n(strobe_n), .i_host_nibble_port(nib_wire),
        .o_host_nibble_port(dev_nib), .o_host_nibble_port_oe(dev_oe),
        .i_sense_inputs(sense), .o_scan_lines(scan),
        .o_antiscan(antiscan), .o_zeroing(zeroing));
    cksp_top #(.SCAN_LINES(SCAN_REDUCED)) i_cksp_top_red (.i_sys_clk(clk),
        .i_resetn(rstn), .i_ale(ale), .i_port_strobe_n(strobe_n),
        .i_host_nibble_port(nib_wire), .o_host_nibble_port(),
        .o_host_nibble_port_oe(), .i_sense_inputs(sense),
        .o_scan_lines(scan_red), .o_antiscan(antiscan_red), .o_zeroing());

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ------------------------------------------------------------------
    // Compare tasks
    // ------------------------------------------------------------------
    task automatic check_scan(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t scan %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_nib(input logic [3:0] got, input logic [3:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t nibble %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_flag(input logic got, input logic exp);
        check_nib({3'h0, got}, {3'h0, exp});
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic write_and_scan(input logic [1:0] port,
                                  input logic [3:0] code);
        logic [15:0] exp;
        exp = 16'h1 << code;
        i_cksp_host_model.do_write(port, code, INSTR_WRITE);
        check_flag(zeroing, 1'b1);
        check_scan(scan, 16'h0);
        @(posedge ale);
        repeat (3) @(negedge clk);
        check_flag(zeroing, 1'b0);
        check_scan(scan, exp);
        check_flag(antiscan, 1'b0);
        check_scan({5'h0, scan_red}, exp & 16'h07ff);
        check_flag(antiscan_red, (exp & 16'h07ff) == 16'h0);
        // The next access then waits one more ALE period: one idle slot
        @(negedge ale);
        repeat (3) @(negedge clk);
        check_scan(scan, 16'h0);
        check_flag(antiscan, 1'b1);
        check_flag(antiscan_red, 1'b1);
    endtask
    task automatic read_check(input logic [1:0] port, input logic [3:0] exp);
        i_cksp_host_model.do_read(port, rd);
        check_nib(rd, exp);
        check_nib(dev_oe, 4'hf);
        repeat (3) @(negedge clk);
        check_nib(dev_oe, 4'h0);
    endtask
    task automatic test_reset;
        check_scan(scan, 16'h0);
        check_flag(antiscan, 1'b1);
        check_flag(zeroing, 1'b0);
        check_nib(dev_oe, 4'h0);
    endtask
    task automatic test_all_codes;
        for (int c = 0; c < 16; c++) begin
            write_and_scan(c[1:0] & PORT_UPPER, c[3:0]);
        end
    endtask
    task automatic test_reads;
        sense = 8'h5c;
        write_and_scan(PORT_LOWER, 4'h2);
        // Pins move after the latch; reads must not follow them
        sense = 8'h00;
        read_check(PORT_UPPER, 4'h5);
        read_check(PORT_LOWER, 4'hc);
        read_check(PORT_UPPER, 4'h5);
    endtask
    task automatic test_ignored;
        logic [1:0] ports [3];
        logic [1:0] instrs [3];
        ports = '{2'h2, 2'h3, 2'h0};
        instrs = '{INSTR_WRITE, 2'h2, 2'h3};
        for (int i = 0; i < 3; i++) begin
            i_cksp_host_model.do_write(ports[i], 4'h6, instrs[i]);
            check_flag(zeroing, 1'b0);
            @(posedge ale);
            repeat (3) @(negedge clk);
            check_scan(scan, 16'h0);
            check_flag(antiscan, 1'b1);
        end
        for (int p = 2; p < 4; p++) begin
            i_cksp_host_model.do_read(p[1:0], rd);
            check_nib(dev_oe, 4'h0);
        end
    endtask
    task automatic test_slow;
        i_cksp_host_model.lo_cyc = 500;
        sense = 8'h3e;
        write_and_scan(PORT_UPPER, 4'h9);
        read_check(PORT_LOWER, 4'he);
        i_cksp_host_model.lo_cyc = 48;
    endtask
    task automatic give_verdict;
        if (fail_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        fail_count++;
        give_verdict();
    end
    initial begin
        rstn = 1'b0;
        sense = 8'h00;
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        test_reset();
        test_all_codes();
        test_reads();
        test_ignored();
        test_slow();
        give_verdict();
    end
endmodule
